// ### rtl/fuse_write_timer.sv
// Purpose: Times one automatic fuse burn, fast or slow.
// Assumes: start arrives only while idle.
// Notes:   Counts are parameters so simulation can shorten them.
`timescale 1ns/10ps
`include "otp_consts.svh"
module fuse_write_timer #(
    parameter int FAST_CYCLES = `MS_TO_CYCLES(`WRITE_FAST_MS),
    parameter int SLOW_CYCLES = `MS_TO_CYCLES(`WRITE_SLOW_MS)
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rstN,
    // Control
    input  wire logic start,
    input  wire logic slow,
    // Status
    output logic      busy,
    output logic      done
);

    otp_pkg::seq_state_t state_r;
    otp_pkg::seq_state_t state_nxt;
    logic [31:0]         count_r;
    logic [31:0]         count_nxt;
    logic                done_r;
    logic                done_nxt;

    // Next state of the burn sequencer
    always_comb begin
        state_nxt = state_r;
        count_nxt = count_r;
        done_nxt  = 1'b0;
        case (state_r)
            otp_pkg::SEQ_IDLE: begin
                if (start) begin
                    state_nxt = otp_pkg::SEQ_BURN;
                    count_nxt = slow ? 32'(SLOW_CYCLES - 1) : 32'(FAST_CYCLES - 1); // R10
                end
            end
            otp_pkg::SEQ_BURN: begin
                if (count_r == 32'h0000_0000) begin
                    state_nxt = otp_pkg::SEQ_IDLE;
                    done_nxt  = 1'b1;
                end else begin
                    count_nxt = count_r - 32'h0000_0001;
                end
            end
            default: begin
                state_nxt = otp_pkg::SEQ_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            state_r <= otp_pkg::SEQ_IDLE;
            count_r <= 32'h0000_0000;
            done_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            count_r <= count_nxt;
            done_r  <= done_nxt;
        end
    end

    assign busy = (state_r == otp_pkg::SEQ_BURN);
    assign done = done_r;

    // Burn length follows the slow select
    property p_burn_length;
        @(posedge core_clk) disable iff (!rstN)
        (start && !busy) |=> (count_r == (slow ? 32'(SLOW_CYCLES - 1) : 32'(FAST_CYCLES - 1)));
    endproperty
    a_burn_length: assert property (p_burn_length) else $error("burn length wrong"); // R10

endmodule

// ### rtl/otp_consts.svh
// Purpose: Named offsets, codes, field positions, reset values and timing for the fuse-programming control.
// Assumes: 100 MHz core clock.
// Notes:   Definitions only.
`ifndef OTP_CONSTS_SVH
`define OTP_CONSTS_SVH

// Register offsets
`define ADDR_FUSE_CTRL   8'h08
`define ADDR_CHECK       8'h0B
`define ADDR_ENTRY       8'h2A
`define ADDR_VALIDATE    8'h36
`define ADDR_COMMAND     8'h39

// Command and unlock codes
`define CODE_ENTRY       8'h3C
`define CODE_VALIDATE    8'h96
`define CODE_FUSE_WRITE  8'hB0

// Field positions
`define BIT_SELECT       0
`define BIT_AUTO_EN      7
`define BIT_SLOW         6
`define BIT_FACTORY_LOCK 5
`define BIT_CUST_LOCK    4
`define BIT_BANK_LOCK    3
`define BIT_RUNNING      2

// Reset values
`define RST_SELECT       1'b1
`define RST_AUTO_EN      1'b0
`define RST_SLOW         1'b0
`define BYTE_ZERO        8'h00

// Timing
`define CLK_MHZ          100
`define WRITE_FAST_MS    100
`define WRITE_SLOW_MS    200
`define MS_TO_CYCLES(ms) ((ms) * 1000 * `CLK_MHZ)

`endif

// ### rtl/otp_mode_entry_and_program.sv
// Purpose: Programming-mode entry, fuse program command and lock/run status.
// Assumes: Serial front end delivers decoded byte writes and reads on core_clk.
// Notes:   Lock inputs come from the fuse array and are synchronised.
// How it works
// R01: Status bit 3 shows bank lock.
// R02: Status bit 2 shows burn running.
// R03: Programmer writes 0x3C to 0x2A first.
// R04: Then 0x96 to 0x36 enters mode.
// R05: Other validation byte leaves programming mode.
// R06: 0xB0 to 0x39 starts burn sequence.
// R07: Command ignored unless mode entered, unlocked.
// R08: Fuse select must be 1 to burn.
// R09: Check bit 7 enables auto programming, resets 0.
// R10: Check bit 6 picks 100 or 200 ms.
// R11: Bit 4 customer lock blocks programming.
`timescale 1ns/10ps
`include "otp_consts.svh"
module otp_mode_entry_and_program #(
    parameter int FAST_CYCLES = `MS_TO_CYCLES(`WRITE_FAST_MS),
    parameter int SLOW_CYCLES = `MS_TO_CYCLES(`WRITE_SLOW_MS)
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             nrst,
    // Register port from serial front end
    input  wire otp_pkg::reg_wr_t regWr,
    input  wire otp_pkg::reg_rd_t regRd,
    output logic [7:0]            regRdData,
    output logic                  regRdValid,
    // Fuse array
    input  wire otp_pkg::fuse_lock_t lockIn,
    output logic                  fuseBurnEn,
    output logic                  fuseTransparent,
    output logic                  programMode
);

    logic [1:0]           rstPipe_r;
    logic                 rstN;
    otp_pkg::fuse_lock_t  lockMeta_r;
    otp_pkg::fuse_lock_t  lockSync_r;
    logic                 armed_r;
    logic                 armed_nxt;
    logic                 modeActive_r;
    logic                 modeActive_nxt;
    logic                 autoEn_r;
    logic                 autoEn_nxt;
    logic                 slow_r;
    logic                 slow_nxt;
    logic                 select_r;
    logic                 select_nxt;
    logic                 burned_r;
    logic                 burned_nxt;
    logic [7:0]           rdData_r;
    logic [7:0]           rdData_nxt;
    logic                 rdValid_r;
    logic                 rdValid_nxt;
    logic                 running;
    logic                 burnDone;
    logic                 bankLockFlag;
    logic                 blocked;
    logic                 cmdHit;
    logic                 start;

    // True for a write strobe to the given offset
    function automatic logic hitWr(input otp_pkg::reg_wr_t w, input logic [7:0] a);
        return w.en && (w.addr == a);
    endfunction

    // Reset release through two flops
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rstPipe_r <= 2'b00;
        end else begin
            rstPipe_r <= {rstPipe_r[0], 1'b1};
        end
    end
    assign rstN = rstPipe_r[1];

    // Lock inputs cross into the core clock
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            lockMeta_r <= '0;
            lockSync_r <= '0;
        end else begin
            lockMeta_r <= lockIn;
            lockSync_r <= lockMeta_r;
        end
    end

    // Lock and command qualification
    // Burn completion locks the bank in the same cycle the burn ends
    assign bankLockFlag = lockSync_r.bank | burned_r | burnDone;                  // R01
    assign blocked      = bankLockFlag | lockSync_r.customer;                              // R11
    assign cmdHit       = hitWr(regWr, `ADDR_COMMAND) && (regWr.data == `CODE_FUSE_WRITE); // R06
    assign start        = cmdHit && modeActive_r && autoEn_r && select_r && !blocked && !running; // R07

    // Next values of control and status
    always_comb begin
        armed_nxt      = armed_r;
        modeActive_nxt = modeActive_r;
        autoEn_nxt     = autoEn_r;
        slow_nxt       = slow_r;
        select_nxt     = select_r;
        burned_nxt     = burned_r | burnDone;
        rdValid_nxt    = regRd.en;
        rdData_nxt     = rdData_r;
        if (hitWr(regWr, `ADDR_ENTRY)) begin
            armed_nxt = (regWr.data == `CODE_ENTRY); // R03
        end
        if (hitWr(regWr, `ADDR_VALIDATE)) begin
            armed_nxt = 1'b0;
            if (regWr.data == `CODE_VALIDATE) begin
                modeActive_nxt = modeActive_r | armed_r; // R04
            end else begin
                modeActive_nxt = 1'b0; // R05
            end
        end
        if (hitWr(regWr, `ADDR_CHECK)) begin
            autoEn_nxt = regWr.data[`BIT_AUTO_EN]; // R09
            slow_nxt   = regWr.data[`BIT_SLOW];    // R10
        end
        if (hitWr(regWr, `ADDR_FUSE_CTRL)) begin
            select_nxt = regWr.data[`BIT_SELECT]; // R08
        end
        if (regRd.en) begin
            case (regRd.addr)
                `ADDR_FUSE_CTRL: begin
                    rdData_nxt = `BYTE_ZERO;
                    rdData_nxt[`BIT_SELECT] = select_r;
                end
                `ADDR_CHECK: begin
                    rdData_nxt = `BYTE_ZERO;
                    rdData_nxt[`BIT_AUTO_EN]      = autoEn_r;
                    rdData_nxt[`BIT_SLOW]         = slow_r;
                    rdData_nxt[`BIT_FACTORY_LOCK] = lockSync_r.factory;
                    rdData_nxt[`BIT_CUST_LOCK]    = lockSync_r.customer; // R11
                    rdData_nxt[`BIT_BANK_LOCK]    = bankLockFlag;        // R01
                    rdData_nxt[`BIT_RUNNING]      = running;             // R02
                end
                default: begin
                    rdData_nxt = `BYTE_ZERO;
                end
            endcase
        end
    end

    // Control and status registers
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            armed_r      <= 1'b0;
            modeActive_r <= 1'b0;
            autoEn_r     <= `RST_AUTO_EN;
            slow_r       <= `RST_SLOW;
            select_r     <= `RST_SELECT;
            burned_r     <= 1'b0;
            rdData_r     <= `BYTE_ZERO;
            rdValid_r    <= 1'b0;
        end else begin
            armed_r      <= armed_nxt;
            modeActive_r <= modeActive_nxt;
            autoEn_r     <= autoEn_nxt;
            slow_r       <= slow_nxt;
            select_r     <= select_nxt;
            burned_r     <= burned_nxt;
            rdData_r     <= rdData_nxt;
            rdValid_r    <= rdValid_nxt;
        end
    end

    // Burn timer
    fuse_write_timer #(
        .FAST_CYCLES (FAST_CYCLES),
        .SLOW_CYCLES (SLOW_CYCLES)
    ) u_timer (
        .core_clk (core_clk),
        .rstN     (rstN),
        .start    (start),
        .slow     (slow_r),
        .busy     (running),
        .done     (burnDone)
    );

    // Outputs
    assign regRdData       = rdData_r;
    assign regRdValid      = rdValid_r;
    assign fuseBurnEn      = running;   // R06
    assign fuseTransparent = !select_r; // R08
    assign programMode     = modeActive_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstN);

    // Read of a status bit reflects state at the request
    property p_lock_read;
        regRd.en && (regRd.addr == `ADDR_CHECK) |=> regRdValid && (regRdData[`BIT_BANK_LOCK] == $past(bankLockFlag));
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("bank lock bit wrong"); // R01

    property p_run_read;
        regRd.en && (regRd.addr == `ADDR_CHECK) |=> (regRdData[`BIT_RUNNING] == $past(running));
    endproperty
    a_run_read: assert property (p_run_read) else $error("running bit wrong"); // R02

    // Entry then validation enters mode
    sequence s_armed_validate;
        armed_r && hitWr(regWr, `ADDR_VALIDATE) && (regWr.data == `CODE_VALIDATE);
    endsequence
    property p_enter;
        s_armed_validate |=> programMode;
    endproperty
    a_enter: assert property (p_enter) else $error("mode entry failed"); // R04

    property p_exit;
        hitWr(regWr, `ADDR_VALIDATE) && (regWr.data != `CODE_VALIDATE) |=> !programMode;
    endproperty
    a_exit: assert property (p_exit) else $error("mode exit failed"); // R05

    // Good command starts the burn
    sequence s_good_cmd;
        cmdHit && programMode && autoEn_r && select_r && !blocked && !running;
    endsequence
    property p_start;
        s_good_cmd |=> running ##1 running;
    endproperty
    a_start: assert property (p_start) else $error("burn did not start"); // R06

    property p_ignore_no_mode;
        cmdHit && !running && !programMode |=> !running;
    endproperty
    a_ignore_no_mode: assert property (p_ignore_no_mode) else $error("burn without mode"); // R07

    property p_need_select;
        cmdHit && !running && !select_r |=> !running;
    endproperty
    a_need_select: assert property (p_need_select) else $error("burn without select"); // R08

    property p_auto_bit;
        hitWr(regWr, `ADDR_CHECK) |=> (autoEn_r == $past(regWr.data[`BIT_AUTO_EN])) && (slow_r == $past(regWr.data[`BIT_SLOW]));
    endproperty
    a_auto_bit: assert property (p_auto_bit) else $error("check bits not stored"); // R09

    property p_cust_lock;
        cmdHit && !running && lockSync_r.customer |=> !running;
    endproperty
    a_cust_lock: assert property (p_cust_lock) else $error("burn while locked"); // R11

    // Finished burn locks the bank
    property p_burn_locks;
        $fell(running) |-> bankLockFlag;
    endproperty
    a_burn_locks: assert property (p_burn_locks) else $error("bank not locked"); // R01

endmodule

// ### rtl/otp_pkg.sv
// Purpose: Types shared by the fuse-programming control.
// Assumes: Byte-wide register port from the serial front end.
// Notes:   Constants live in otp_consts.svh.
package otp_pkg;

    // One register write
    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_wr_t;

    // One register read request
    typedef struct packed {
        logic       en;
        logic [7:0] addr;
    } reg_rd_t;

    // Lock indications from the fuse array
    typedef struct packed {
        logic factory;
        logic customer;
        logic bank;
    } fuse_lock_t;

    // Burn sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_BURN = 2'b10
    } seq_state_t;

endpackage

// ### test/programmer_model.sv
// Purpose: Behavioural external programmer driving the byte register port.
// Assumes: One-cycle strobes, launched 1 ns after core_clk rises.
// Notes:   Idle address and data lines carry the inverse of the last values.
`timescale 1ns/10ps
`include "otp_consts.svh"
module programmer_model (
    // Clock
    input  wire logic        core_clk,
    // Register port
    output otp_pkg::reg_wr_t regWr,
    output otp_pkg::reg_rd_t regRd
);
    int slowGap = 0;

    // Quiet port at time zero
    initial begin
        regWr = '0;
        regRd = '0;
    end

    // One byte write, idle gap first when slow
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        repeat (slowGap) @(posedge core_clk);
        @(posedge core_clk);
        #1 regWr = '{en: 1'b1, addr: a, data: d};
        @(posedge core_clk);
        #1 regWr = '{en: 1'b0, addr: ~a, data: ~d};
    endtask

    // One byte read request
    task automatic rd(input logic [7:0] a);
        repeat (slowGap) @(posedge core_clk);
        @(posedge core_clk);
        #1 regRd = '{en: 1'b1, addr: a};
        @(posedge core_clk);
        #1 regRd = '{en: 1'b0, addr: ~a};
    endtask

    // Mode entry code, then validation code
    task automatic enterMode();
        wr(`ADDR_ENTRY, `CODE_ENTRY);
        wr(`ADDR_VALIDATE, `CODE_VALIDATE);
    endtask

    // Cells made non-transparent before a burn
    task automatic prepare();
        wr(`ADDR_FUSE_CTRL, 8'h01);
    endtask

    // Program command
    task automatic burn();
        wr(`ADDR_COMMAND, `CODE_FUSE_WRITE);
    endtask
endmodule

// ### test/test_otp_mode_entry_and_program.sv
// Purpose: Self-checking bench for mode entry, program command and status.
// Assumes: Burn counts shortened to 20 and 40 cycles.
// Notes:   Reads are queued by the driver and checked by a monitor.
`timescale 1ns/10ps
`include "otp_consts.svh"
module test_otp_mode_entry_and_program;
    localparam int FAST = 20;
    localparam int SLOW = 40;
    logic                core_clk = 1'b0;
    logic                nrst     = 1'b0;
    otp_pkg::reg_wr_t    regWr;
    otp_pkg::reg_rd_t    regRd;
    otp_pkg::fuse_lock_t lockIn   = '0;
    logic [7:0]          regRdData;
    logic                regRdValid;
    logic                fuseBurnEn;
    logic                fuseTransparent;
    logic                programMode;
    logic [7:0]          expQ[$];
    logic [7:0]          rnd;
    int                  err_total   = 0;
    int                  checks_done = 0;
    int                  burnCnt     = 0;
    int                  seed        = 52896;

    // Clock
    always #5 core_clk = ~core_clk;

    otp_mode_entry_and_program #(.FAST_CYCLES(FAST), .SLOW_CYCLES(SLOW)) DUT (
        .core_clk(core_clk), .nrst(nrst), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .regRdValid(regRdValid), .lockIn(lockIn),
        .fuseBurnEn(fuseBurnEn), .fuseTransparent(fuseTransparent), .programMode(programMode));

    programmer_model u_prog (.core_clk(core_clk), .regWr(regWr), .regRd(regRd));

    task automatic chkBit(input string what, input logic e, input logic s);
        checks_done++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %b seen %b", what, e, s);
        end
    endtask

    task automatic chkByte(input string what, input logic [7:0] e, input logic [7:0] s);
        checks_done++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic chkCnt(input string what, input int e, input int s);
        checks_done++;
        if (s != e) begin
            err_total++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, e, s);
        end
    endtask

    // Monitor: burn cycle count and queued read results
    always @(posedge core_clk) begin
        if (fuseBurnEn === 1'b1)
            burnCnt++;
        if (regRdValid === 1'b1) begin
            if (expQ.size() == 0)
                chkCnt("read results pending", 1, 0);
            else
                chkByte("read data", expQ.pop_front(), regRdData);
        end
    end

    task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        u_prog.rd(a);
    endtask

    task automatic settle();
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task automatic noBurn();
        repeat (3) @(posedge core_clk);
        #1 chkBit("burn idle", 1'b0, fuseBurnEn);
    endtask

    task automatic doReset();
        nrst = 1'b0;
        repeat (16) @(posedge core_clk);
        #1 nrst = 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
    endtask

    // Burn, status while running, length, status after
    task automatic burnRun(input int n, input logic [7:0] during, input logic [7:0] after);
        burnCnt = 0;
        u_prog.burn();
        rdChk(`ADDR_CHECK, during);
        repeat (n + 8) @(posedge core_clk);
        #1 chkCnt("burn length", n, burnCnt);
        rdChk(`ADDR_CHECK, after);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Watchdog
    initial begin
        #100000;
        err_total++;
        $display("watchdog expired");
        give_verdict();
    end

    // Main sequence
    initial begin
        doReset();
        chkBit("program mode", 1'b0, programMode);
        chkBit("transparent", 1'b0, fuseTransparent);
        rdChk(`ADDR_CHECK, 8'h00);
        rdChk(`ADDR_FUSE_CTRL, 8'h01);
        rdChk(`ADDR_ENTRY, 8'h00);
        rdChk(`ADDR_VALIDATE, 8'h00);
        rdChk(`ADDR_COMMAND, 8'h00);
        rnd = 8'($random(seed));
        rnd[7:6] = 2'b01;
        rdChk(rnd, 8'h00);
        $display("test reset done");

        u_prog.wr(`ADDR_VALIDATE, `CODE_VALIDATE);
        settle();
        chkBit("program mode", 1'b0, programMode);
        u_prog.enterMode();
        settle();
        chkBit("program mode", 1'b1, programMode);
        rnd = 8'($random(seed));
        if (rnd == `CODE_VALIDATE)
            rnd = 8'h69;
        u_prog.wr(`ADDR_VALIDATE, rnd);
        settle();
        chkBit("program mode", 1'b0, programMode);
        u_prog.wr(`ADDR_ENTRY, 8'h3D);
        u_prog.wr(`ADDR_VALIDATE, `CODE_VALIDATE);
        settle();
        chkBit("program mode", 1'b0, programMode);
        u_prog.slowGap = 3;
        u_prog.enterMode();
        u_prog.slowGap = 0;
        settle();
        chkBit("program mode", 1'b1, programMode);
        $display("test entry done");

        u_prog.wr(`ADDR_FUSE_CTRL, 8'h00);
        settle();
        chkBit("transparent", 1'b1, fuseTransparent);
        u_prog.wr(`ADDR_CHECK, 8'h80);
        u_prog.burn();
        noBurn();
        u_prog.prepare();
        u_prog.wr(`ADDR_CHECK, 8'h00);
        u_prog.burn();
        noBurn();
        u_prog.wr(`ADDR_CHECK, 8'h80);
        lockIn.customer = 1'b1;
        repeat (4) @(posedge core_clk);
        rdChk(`ADDR_CHECK, 8'h90);
        u_prog.burn();
        noBurn();
        lockIn.customer = 1'b0;
        u_prog.wr(`ADDR_COMMAND, 8'hB1);
        noBurn();
        burnRun(FAST, 8'h84, 8'h88);
        u_prog.burn();
        noBurn();
        $display("test fast burn done");

        lockIn = '{factory: 1'b1, customer: 1'b0, bank: 1'b1};
        doReset();
        rdChk(`ADDR_CHECK, 8'h28);
        u_prog.wr(`ADDR_CHECK, 8'h80);
        u_prog.enterMode();
        u_prog.burn();
        noBurn();
        lockIn = '0;
        doReset();
        u_prog.wr(`ADDR_CHECK, 8'hC0);
        u_prog.burn();
        noBurn();
        u_prog.enterMode();
        burnRun(SLOW, 8'hC4, 8'hC8);
        $display("test lock and slow burn done");

        repeat (3) @(posedge core_clk);
        chkCnt("reads outstanding", 0, expQ.size());
        give_verdict();
    end
endmodule
